//--- bench/link_peer.sv
// far-side serial peripheral that clocks frames and exchanges words
`timescale 1ns/1ns
module link_peer (
    // serial pins
    output logic link_clock,
    output logic serial_in,
    input  logic serial_out
);
    // clock stands low between frames
    initial begin
        link_clock = 1'b0;
        serial_in  = 1'b0;
    end
    // one frame msb first, 320 ns per bit; sample our input on each rise
    task automatic frame(input logic [15:0] send, input int nbits, output logic [15:0] got);
        got = 16'h0000;
        #10; // keep link edges off the sampling edge of pclk
        for (int i = nbits - 1; i >= 0; i--) begin
            serial_in  = send[i];
            #160;
            link_clock = 1'b1;
            got        = {got[14:0], serial_out};
            #160;
            link_clock = 1'b0;
        end
        serial_in = ~serial_in; // released line never repeats the last bit
    endtask
endmodule

//--- bench/serial_buf_chk.sv
// port-level assertion checker for the serial buffer block
`timescale 1ns/1ns
`include "serial_buf_defines.vh"
module serial_buf_chk (
    // clock and reset
    input logic        pclk,
    input logic        presetn,
    // apb slave
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [31:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // fifo and dma status and controls
    input logic        tx_fifo_is_full,
    input logic        rx_fifo_is_full,
    input logic        tx_trigger_reached,
    input logic        rx_trigger_reached,
    input logic        tx_page_boundary,
    input logic        rx_page_boundary,
    input logic        tx_fifo_use,
    input logic        tx_dma_use,
    input logic        rx_fifo_use,
    input logic        rx_dma_use,
    input logic        tx_halt,
    input logic        rx_halt
);
    localparam logic [31:0] A_CTL = `IDX_CONTROL * 4;
    logic [15:0] ctl;
    // decoded bus events and halt causes from the mirrored control bits
    wire mapped   = paddr inside {`IDX_MODE * 4, `IDX_RX_BUF * 4, `IDX_TX_BUF * 4,
                    `IDX_RX_COPY * 4, `IDX_FIRST_TX * 4, `IDX_SHIFT * 4, A_CTL};
    wire ctl_rd   = pready & ~pwrite & (paddr == A_CTL);
    wire tx_cause = (ctl[12] & tx_trigger_reached) | (ctl[9] & tx_page_boundary);
    wire rx_cause = (ctl[5] & rx_fifo_is_full) | (ctl[4] & rx_trigger_reached)
                  | (ctl[1] & rx_page_boundary);
    // mirror of the writable control bits, taken at each completed write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctl <= `CTL_RESET;
        else if (psel & penable & pready & pwrite & (paddr == A_CTL))
            ctl <= pwdata[15:0] & `CTL_WMASK;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> s_answer)
        else $error("no single-cycle ready after setup");
    a_error_on_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("error response does not match address decode");
    a_error_needs_ready: assert property (pslverr |-> pready)
        else $error("error response without ready");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero outside access");
    a_ctl_readback: assert property (ctl_rd |-> ((prdata[15:0] & `CTL_WMASK) == ctl
        && prdata[14:13] == 2'b00 && prdata[31:16] == 16'h0000))
        else $error("control read differs from written value");
    a_full_flags: assert property (ctl_rd |-> prdata[11] == $past(tx_fifo_is_full)
        && prdata[3] == $past(rx_fifo_is_full))
        else $error("fifo full flags misreported");
    a_use_outputs: assert property ({tx_fifo_use, tx_dma_use, rx_fifo_use, rx_dma_use}
        == {ctl[10], ctl[8], ctl[2], ctl[0]})
        else $error("fifo or dma enable output wrong");
    a_tx_halt_late: assert property (tx_halt == $past(tx_cause))
        else $error("transmit halt wrong");
    a_rx_halt_late: assert property (rx_halt == $past(rx_cause))
        else $error("receive halt wrong");
endmodule

//--- bench/serial_buffers_and_fifo_control_tb_top.sv
// testbench for the serial buffer block
`timescale 1ns/1ns
`include "serial_buf_defines.vh"
module serial_buffers_and_fifo_control_tb_top;
    localparam logic [31:0] A_MODE = `IDX_MODE * 4;
    localparam logic [31:0] A_RXB  = `IDX_RX_BUF * 4;
    localparam logic [31:0] A_TXB  = `IDX_TX_BUF * 4;
    localparam logic [31:0] A_COPY = `IDX_RX_COPY * 4;
    localparam logic [31:0] A_FTX  = `IDX_FIRST_TX * 4;
    localparam logic [31:0] A_SHF  = `IDX_SHIFT * 4;
    localparam logic [31:0] A_CTL  = `IDX_CONTROL * 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic        link_clock, serial_in, serial_out, tfu, tdu, rfu, rdu, tx_halt, rx_halt;
    logic [5:0]  st;
    logic [15:0] got;
    int          fail_count, compares, cycles;
    serial_buffers_and_fifo_control dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_clock(link_clock), .serial_in(serial_in), .serial_out(serial_out),
        .tx_fifo_is_full(st[5]), .rx_fifo_is_full(st[4]), .tx_trigger_reached(st[3]),
        .rx_trigger_reached(st[2]), .tx_page_boundary(st[1]), .rx_page_boundary(st[0]),
        .tx_fifo_use(tfu), .tx_dma_use(tdu), .rx_fifo_use(rfu), .rx_dma_use(rdu),
        .tx_halt(tx_halt), .rx_halt(rx_halt));
    link_peer peer (.link_clock(link_clock), .serial_in(serial_in), .serial_out(serial_out));
    // 25 mhz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer: setup, then access until ready
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            fail_count++;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask
    // poll the busy bit of the mode register
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, A_MODE, 32'h0000_0000);
            n++;
        end while (rd[`MODE_BUSY] !== 1'b0 && n < 100);
        if (rd[`MODE_BUSY] !== 1'b0)
            fail_count++;
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            end_sim;
        end
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, st} = '0;
        {fail_count, compares, cycles} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(A_CTL, 32'h0000_8000);
        rdchk(A_COPY, 32'h0000_0000);
        rdchk(A_FTX, 32'h0000_0000);
        rdchk(A_SHF, 32'h0000_0000);
        rdchk(32'h0000_0100, 32'h0000_0000);
        check({31'h0, err}, 32'h1);
        wr(A_FTX, 32'h0000_00ab);
        rdchk(A_FTX, 32'h0000_0000);
        wr(A_MODE, 32'h0000_0004);
        wr(A_CTL, 32'h0000_7fff);
        rdchk(A_CTL, 32'h0000_1737);
        check({28'h0, tfu, tdu, rfu, rdu}, 32'h0000_000f);
        for (int i = 0; i < 7; i++) begin
            st <= 6'h01 << i;
            repeat (3) @(posedge pclk);
        end
        st <= 6'h3f;
        rdchk(A_CTL, 32'h0000_1f3f);
        check({30'h0, tx_halt, rx_halt}, 32'h0000_0003);
        wr(A_CTL, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        check({30'h0, tx_halt, rx_halt}, 32'h0000_0000);
        st <= 6'h00;
        wr(A_MODE, 32'h0000_000c);
        wr(A_SHF, 32'h0000_abcd);
        rdchk(A_SHF, 32'h0000_00cd);
        wr(A_MODE, 32'h0000_000e);
        wr(A_SHF, 32'h0000_1234);
        rdchk(A_SHF, 32'h0000_1234);
        rdchk(A_RXB, 32'h0000_0000);
        peer.frame(16'h5a3c, 16, got);
        wait_idle;
        rdchk(A_SHF, 32'h0000_5a3c);
        rdchk(A_COPY, 32'h0000_1234);
        rdchk(A_MODE, 32'h0000_000e);
        rdchk(A_RXB, 32'h0000_1234);
        peer.frame(16'hc3a5, 16, got);
        wait_idle;
        rdchk(A_SHF, 32'h0000_c3a5);
        rdchk(A_COPY, 32'h0000_5a3c);
        rdchk(A_CTL, 32'h0000_00c0);
        wr(A_MODE, 32'h0000_000f);
        rdchk(A_COPY, 32'h0000_0000);
        wr(A_MODE, 32'h0000_000e);
        rdchk(A_COPY, 32'h0000_5a3c);
        wr(A_CTL, 32'h0000_8000);
        rdchk(A_SHF, 32'h0000_0000);
        rdchk(A_COPY, 32'h0000_0000);
        rdchk(A_CTL, 32'h0000_8000);
        wr(A_CTL, 32'h0000_0000);
        wr(A_SHF, 32'h0000_0077);
        rdchk(A_SHF, 32'h0000_0077);
        wr(A_MODE, 32'h0000_0006);
        rdchk(A_SHF, 32'h0000_0000);
        wr(A_MODE, 32'h0000_0009);
        wr(A_FTX, 32'h0000_0042);
        wr(A_TXB, 32'h0000_0196);
        wr(A_FTX, 32'h0000_0099);
        peer.frame(16'h0000, 8, got);
        check({16'h0, got}, 32'h0000_0096);
        wait_idle;
        rdchk(A_FTX, 32'h0000_0042);
        wr(A_MODE, 32'h0000_000d);
        wr(A_FTX, 32'h0000_005a);
        wr(A_TXB, 32'h0000_00c3);
        peer.frame(16'h0000, 16, got);
        check({16'h0, got}, 32'h0000_5ac3);
        wait_idle;
        wr(A_CTL, 32'h0000_8000);
        rdchk(A_FTX, 32'h0000_0000);
        end_sim;
    end
endmodule
bind serial_buffers_and_fifo_control serial_buf_chk chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_fifo_is_full(tx_fifo_is_full), .rx_fifo_is_full(rx_fifo_is_full),
    .tx_trigger_reached(tx_trigger_reached), .rx_trigger_reached(rx_trigger_reached),
    .tx_page_boundary(tx_page_boundary), .rx_page_boundary(rx_page_boundary),
    .tx_fifo_use(tx_fifo_use), .tx_dma_use(tx_dma_use), .rx_fifo_use(rx_fifo_use),
    .rx_dma_use(rx_dma_use), .tx_halt(tx_halt), .rx_halt(rx_halt));

//--- hdl/serial_buf_defines.vh
// register indices, field positions and reset values of the serial buffer block
`ifndef SERIAL_BUF_DEFINES_VH
`define SERIAL_BUF_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_MODE        32'h0f0001a0
`define IDX_RX_BUF      32'h0f0001a2
`define IDX_TX_BUF      32'h0f0001a4
`define IDX_RX_COPY     32'h0f0001a6
`define IDX_FIRST_TX    32'h0f0001a8
`define IDX_SHIFT       32'h0f0001aa
`define IDX_CONTROL     32'h0f0001b0

// mode register fields
`define MODE_DIR        0
`define MODE_LEN        1
`define MODE_SEQ        2
`define MODE_EN         3
`define MODE_BUSY       4

// control register fields
`define CTL_URST        15
`define CTL_TTRG        12
`define CTL_TFULL       11
`define CTL_TFIFO       10
`define CTL_TPAGE       9
`define CTL_TDMA        8
`define CTL_SVALID      7
`define CTL_RVALID      6
`define CTL_RFULLS      5
`define CTL_RTRG        4
`define CTL_RFULL       3
`define CTL_RFIFO       2
`define CTL_RPAGE       1
`define CTL_RDMA        0

// reset values and masks
`define CTL_RESET       16'h8000
`define CTL_WMASK       16'h9737
`define DATA_ZERO       16'h0000
`define MASK_BYTE       16'h00ff
`define MASK_WORD       16'hffff

// character lengths in bits
`define BITS_BYTE       5'd8
`define BITS_WORD       5'd16

`endif

//--- hdl/serial_buffers_and_fifo_control.v
// serial buffers, shift engine and control register behind an apb slave
//
// Function
// R1: reading copy or shift register never starts reception; only receive buffer read does
// R2: copy register shows receive data only while direction selects receive
// R3: copy, first-transmit and shift registers clear on reset or unit soft reset
// R4: shift register also clears when the interface enable bit is cleared
// R5: character length 0 uses low 8 bits, 1 uses all 16 bits
// R6: in sequential mode software loads first-transmit before the transmit buffer
// R7: first-transmit writes only take effect while no transfer is in progress
// R8: shift register writes only take effect while no transfer is in progress
// R9: after sequential reception last word stays in shift, previous in buffer and copy
// R10: control bit 15 holds unit in reset; software clears it before configuring
// R11: control register resets with bit 15 set and all others clear
// R12: bit 12 halts transmission at the transmit trigger level
// R13: read-only bit 11 shows transmit fifo full
// R14: bit 10 enables transmit fifo, bit 8 enables transmit dma
// R15: bit 9 halts transfer at transmit dma one-page boundary
// R16: bits 7 and 6 show valid data in shift register and receive buffer
// R17: bit 5 halts reception when receive fifo is full
// R18: bit 4 halts reception at the receive trigger level
// R19: read-only bit 3 shows receive fifo full
// R20: bit 2 enables receive fifo, bit 0 receive dma, bit 1 receive page halt
// R21: software sets sequential mode whenever either fifo is enabled
// R22: software enables the fifos whenever dma is enabled
// R23: in sequential mode a receive buffer read triggers the next reception
// R24: without transmit fifo a transmit buffer write starts transmission
// R25: control bits 14 and 13 read zero and ignore writes
// R26: valid flags clear on unit soft reset or when their register clears
`timescale 1ns/1ns
`include "serial_buf_defines.vh"

module serial_buffers_and_fifo_control (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // serial link
    input  wire        link_clock,
    input  wire        serial_in,
    output reg         serial_out,
    // fifo and dma status from neighbouring logic
    input  wire        tx_fifo_is_full,
    input  wire        rx_fifo_is_full,
    input  wire        tx_trigger_reached,
    input  wire        rx_trigger_reached,
    input  wire        tx_page_boundary,
    input  wire        rx_page_boundary,
    // fifo and dma controls
    output wire        tx_fifo_use,
    output wire        tx_dma_use,
    output wire        rx_fifo_use,
    output wire        rx_dma_use,
    output reg         tx_halt,
    output reg         rx_halt
);

    // one-hot states of the shift engine
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_SHIFT = 3'b010;
    localparam [2:0] ST_DONE  = 3'b100;

    reg  [15:0] receive_buffer_data;
    reg  [15:0] receive_copy_data;
    reg  [15:0] first_transmit_data;
    reg  [15:0] transmit_data;
    reg  [15:0] shift_data;
    reg         shift_data_valid;
    reg         receive_buffer_valid;
    reg         tx_pending;
    reg         transfer_direction;
    reg         character_length;
    reg         seq_mode;
    reg         interface_enable;
    reg         transfer_in_progress;
    reg  [15:0] control;
    reg  [2:0]  state;
    reg  [4:0]  bit_count;
    reg         clk_meta;
    reg         clk_sync;
    reg         clk_last;
    reg         din_meta;
    reg         din_sync;
    reg  [31:0] next_rdata;

    // byte address of a register index
    function [31:0] byte_addr;
        input [31:0] idx;
        begin
            byte_addr = {idx[29:0], 2'b00};
        end
    endfunction

    // most significant bit of the current character
    function msb_of;
        input [15:0] v;
        input        long;
        begin
            msb_of = long ? v[15] : v[7];
        end
    endfunction

    // apb phases; side effects only at the completing edge
    wire setup  = psel & ~penable;
    wire access = psel & penable & pready;
    wire wr     = access & pwrite;
    wire rd     = access & ~pwrite;

    // address decode
    wire hit_mode  = (paddr == byte_addr(`IDX_MODE));
    wire hit_rxb   = (paddr == byte_addr(`IDX_RX_BUF));
    wire hit_txb   = (paddr == byte_addr(`IDX_TX_BUF));
    wire hit_copy  = (paddr == byte_addr(`IDX_RX_COPY));
    wire hit_ftx   = (paddr == byte_addr(`IDX_FIRST_TX));
    wire hit_shift = (paddr == byte_addr(`IDX_SHIFT));
    wire hit_ctl   = (paddr == byte_addr(`IDX_CONTROL));
    wire hit_any   = hit_mode | hit_rxb | hit_txb | hit_copy | hit_ftx | hit_shift | hit_ctl;

    // character width in use
    wire [15:0] len_mask  = character_length ? `MASK_WORD : `MASK_BYTE; // R5
    wire [4:0]  char_bits = character_length ? `BITS_WORD : `BITS_BYTE; // R5
    wire [15:0] wdata     = pwdata[15:0] & len_mask; // R5

    wire unit_soft_reset = control[`CTL_URST]; // R10
    wire run_ok          = interface_enable & ~unit_soft_reset; // R10

    // halt conditions
    wire tx_halt_now = (control[`CTL_TTRG] & tx_trigger_reached) // R12
                     | (control[`CTL_TPAGE] & tx_page_boundary); // R15
    wire rx_halt_now = (control[`CTL_RFULLS] & rx_fifo_is_full) // R17
                     | (control[`CTL_RTRG] & rx_trigger_reached) // R18
                     | (control[`CTL_RPAGE] & rx_page_boundary); // R20

    // transfer starts; only the receive buffer read triggers reception
    wire tx_start = wr & hit_txb & transfer_direction & ~control[`CTL_TFIFO] // R24
                  & run_ok & ~transfer_in_progress & ~tx_halt_now;
    wire rx_start = rd & hit_rxb & ~transfer_direction // R1 R23
                  & run_ok & ~transfer_in_progress & ~rx_halt_now;

    // link clock edges seen on the synchronised copy
    wire clk_rise = clk_sync & ~clk_last;
    wire clk_fall = ~clk_sync & clk_last;

    // fifo and dma enables straight from the control flops
    assign tx_fifo_use = control[`CTL_TFIFO]; // R14
    assign tx_dma_use  = control[`CTL_TDMA]; // R14
    assign rx_fifo_use = control[`CTL_RFIFO]; // R20
    assign rx_dma_use  = control[`CTL_RDMA]; // R20

    // two-stage synchronisers for the link pins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_meta <= 1'b0;
            clk_sync <= 1'b0;
            clk_last <= 1'b0;
            din_meta <= 1'b0;
            din_sync <= 1'b0;
        end else begin
            clk_meta <= link_clock;
            clk_sync <= clk_meta;
            clk_last <= clk_sync;
            din_meta <= serial_in;
            din_sync <= din_meta;
        end
    end

    // control register; reserved bits never stored
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= `CTL_RESET; // R11
        end else if (wr && hit_ctl) begin
            control <= pwdata[15:0] & `CTL_WMASK; // R25
        end
    end

    // mode register; shape bits locked while a transfer runs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transfer_direction <= 1'b0;
            character_length   <= 1'b0;
            seq_mode           <= 1'b0;
            interface_enable   <= 1'b0;
        end else if (wr && hit_mode) begin
            interface_enable <= pwdata[`MODE_EN];
            if (!transfer_in_progress) begin
                transfer_direction <= pwdata[`MODE_DIR];
                character_length   <= pwdata[`MODE_LEN];
                seq_mode           <= pwdata[`MODE_SEQ];
            end
        end
    end

    // halt outputs registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_halt <= 1'b0;
            rx_halt <= 1'b0;
        end else begin
            tx_halt <= tx_halt_now; // R12 R15
            rx_halt <= rx_halt_now; // R17 R18 R20
        end
    end

    // read data selection
    always @* begin
        next_rdata = 32'h0000_0000;
        case (1'b1)
            hit_mode: begin
                next_rdata[`MODE_DIR]  = transfer_direction;
                next_rdata[`MODE_LEN]  = character_length;
                next_rdata[`MODE_SEQ]  = seq_mode;
                next_rdata[`MODE_EN]   = interface_enable;
                next_rdata[`MODE_BUSY] = transfer_in_progress;
            end
            hit_rxb: begin
                next_rdata[15:0] = transfer_direction ? `DATA_ZERO : receive_buffer_data;
            end
            hit_txb: begin
                next_rdata[15:0] = transmit_data;
            end
            hit_copy: begin
                next_rdata[15:0] = transfer_direction ? `DATA_ZERO : receive_copy_data; // R2
            end
            hit_ftx: begin
                next_rdata[15:0] = first_transmit_data;
            end
            hit_shift: begin
                next_rdata[15:0] = shift_data;
            end
            hit_ctl: begin
                next_rdata[15:0]        = control;
                next_rdata[`CTL_TFULL]  = tx_fifo_is_full; // R13
                next_rdata[`CTL_SVALID] = shift_data_valid; // R16
                next_rdata[`CTL_RVALID] = receive_buffer_valid; // R16
                next_rdata[`CTL_RFULL]  = rx_fifo_is_full; // R19
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // apb answer: ready in the first access cycle, error on unmapped address
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~hit_any;
            prdata  <= setup ? next_rdata : 32'h0000_0000;
        end
    end

    // data registers and shift engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_buffer_data  <= `DATA_ZERO; // R3
            receive_copy_data    <= `DATA_ZERO; // R3
            first_transmit_data  <= `DATA_ZERO; // R3
            transmit_data        <= `DATA_ZERO;
            shift_data           <= `DATA_ZERO; // R3
            shift_data_valid     <= 1'b0;
            receive_buffer_valid <= 1'b0;
            tx_pending           <= 1'b0;
            transfer_in_progress <= 1'b0;
            state                <= ST_IDLE;
            bit_count            <= 5'd0;
            serial_out           <= 1'b0;
        end else if (unit_soft_reset) begin
            receive_buffer_data  <= `DATA_ZERO; // R3
            receive_copy_data    <= `DATA_ZERO; // R3
            first_transmit_data  <= `DATA_ZERO; // R3
            transmit_data        <= `DATA_ZERO;
            shift_data           <= `DATA_ZERO; // R3
            shift_data_valid     <= 1'b0; // R26
            receive_buffer_valid <= 1'b0; // R26
            tx_pending           <= 1'b0;
            transfer_in_progress <= 1'b0;
            state                <= ST_IDLE;
            bit_count            <= 5'd0;
            serial_out           <= 1'b0;
        end else if (!interface_enable) begin
            shift_data           <= `DATA_ZERO; // R4
            shift_data_valid     <= 1'b0; // R26
            transmit_data        <= `DATA_ZERO;
            tx_pending           <= 1'b0;
            transfer_in_progress <= 1'b0;
            state                <= ST_IDLE;
            bit_count            <= 5'd0;
            serial_out           <= 1'b0;
            if (wr && hit_ftx && !transfer_in_progress) begin
                first_transmit_data <= wdata; // R7
            end
        end else begin
            // software writes outside the shift engine
            if (wr && hit_ftx && !transfer_in_progress) begin
                first_transmit_data <= wdata; // R7
            end
            if (wr && hit_txb && transfer_direction) begin
                transmit_data <= wdata;
                if (transfer_in_progress && seq_mode) begin
                    tx_pending <= 1'b1;
                end
            end
            case (state)
                ST_IDLE: begin
                    if (wr && hit_shift && !transfer_in_progress) begin
                        shift_data <= wdata; // R8
                    end
                    if (tx_start) begin
                        // sequential mode sends the first-transmit word ahead
                        shift_data           <= seq_mode ? first_transmit_data : wdata; // R6 R24
                        serial_out           <= msb_of(seq_mode ? first_transmit_data : wdata,
                                                       character_length);
                        tx_pending           <= seq_mode;
                        shift_data_valid     <= 1'b0;
                        transfer_in_progress <= 1'b1;
                        bit_count            <= 5'd0;
                        state                <= ST_SHIFT;
                    end else if (rx_start) begin
                        // previous word moves to buffer and copy together
                        receive_buffer_data  <= shift_data; // R9
                        receive_copy_data    <= shift_data; // R9
                        receive_buffer_valid <= shift_data_valid; // R26
                        shift_data_valid     <= 1'b0;
                        serial_out           <= msb_of(shift_data, character_length);
                        transfer_in_progress <= 1'b1;
                        bit_count            <= 5'd0;
                        state                <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (clk_rise) begin
                        shift_data <= {shift_data[14:0], din_sync} & len_mask; // R5
                        bit_count  <= bit_count + 5'd1;
                        if (bit_count + 5'd1 == char_bits) begin
                            state <= ST_DONE;
                        end
                    end else if (clk_fall) begin
                        serial_out <= msb_of(shift_data, character_length);
                    end
                end
                ST_DONE: begin
                    shift_data_valid <= 1'b1; // R16
                    if (transfer_direction && seq_mode && tx_pending && !tx_halt_now) begin
                        // next sequential word follows without a gap
                        shift_data       <= transmit_data;
                        serial_out       <= msb_of(transmit_data, character_length);
                        shift_data_valid <= 1'b0;
                        tx_pending       <= 1'b0;
                        bit_count        <= 5'd0;
                        state            <= ST_SHIFT;
                    end else begin
                        transfer_in_progress <= 1'b0; // R9
                        state                <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule
